// file: core/ppi_pkg.sv
// Shared constants for the priority partitioning identification bank
package ppi_pkg;

  // Bus geometry and table sizes
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int NUM_SPACE = 4;
  localparam int NUM_RI = 4;
  localparam int RIS_W = 2;
  localparam int WD_W = 6;

  // Register offsets inside each feature page
  localparam logic [ADDR_W-1:0] OFF_SECURE_LIMITS = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_PRIORITY_FEATURE = 12'h048;

  // Field layout of the priority feature word
  localparam int DS_WD_LSB = 20;
  localparam int DS_WD_MSB = 25;
  localparam int DS_ZERO_LOW_BIT = 17;
  localparam int DS_PRESENT_BIT = 16;
  localparam int INT_WD_LSB = 4;
  localparam int INT_WD_MSB = 9;
  localparam int INT_ZERO_LOW_BIT = 1;
  localparam int INT_PRESENT_BIT = 0;

  // Field layout of the secure limits word
  localparam int SMG_LSB = 16;
  localparam int SMG_MSB = 23;
  localparam int SPL_LSB = 0;
  localparam int SPL_MSB = 15;

  // Legal range of an implemented priority width
  localparam logic [WD_W-1:0] PRI_WD_MIN = 6'h01;
  localparam logic [WD_W-1:0] PRI_WD_MAX = 6'h10;

  // Reset values of the answer path
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h00000000;
  localparam logic ACK_RST = 1'b0;
  localparam logic ERR_RST = 1'b0;

  // Security space carried with every access
  typedef enum logic [1:0] {
    SPACE_SECURE,
    SPACE_NONSECURE,
    SPACE_ROOT,
    SPACE_REALM
  } ppi_space_t;

  // Capability tables, indexed by space then resource instance
  typedef logic [NUM_SPACE-1:0][NUM_RI-1:0][WD_W-1:0] ppi_wd_tab_t;
  typedef logic [NUM_SPACE-1:0][NUM_RI-1:0] ppi_bit_tab_t;

  // Default implemented capabilities
  localparam ppi_wd_tab_t DEF_DS_WD = {16{6'h08}};
  localparam ppi_wd_tab_t DEF_INT_WD = {16{6'h04}};
  localparam ppi_bit_tab_t DEF_DS_PRESENT = 16'hffff;
  localparam ppi_bit_tab_t DEF_INT_PRESENT = 16'hffff;
  localparam ppi_bit_tab_t DEF_DS_ZERO_LOW = 16'h0000;
  localparam ppi_bit_tab_t DEF_INT_ZERO_LOW = 16'hffff;
  localparam logic DEF_INSTANCE_SELECT = 1'b1;
  localparam logic [15:0] DEF_SECURE_PARTITION_LIMIT = 16'h00ff;
  localparam logic [7:0] DEF_SECURE_MONITOR_GROUP_LIMIT = 8'h01;

endpackage

// file: core/ppi_pri_word.sv
`timescale 1ns/10ps
// Packs one resource instance's priority capabilities into the feature word
module ppi_pri_word
  import ppi_pkg::*;
(
  input wire logic [WD_W-1:0] ds_width, // Downstream priority bits implemented
  input wire logic ds_present, // Downstream priority field exists
  input wire logic ds_zero_low, // Downstream zero is lowest
  input wire logic [WD_W-1:0] int_width, // Internal priority bits implemented
  input wire logic int_present, // Internal priority field exists
  input wire logic int_zero_low, // Internal zero is lowest
  output logic [DATA_W-1:0] word // Packed feature word
);

  // Keeps a width legal even if a table entry is mistyped
  function automatic logic [WD_W-1:0] legal_width(input logic [WD_W-1:0] w,
                                                  input logic present);
    logic [WD_W-1:0] r;
    r = '0;
    if (present) begin
      if (w < PRI_WD_MIN) r = PRI_WD_MIN;
      else if (w > PRI_WD_MAX) r = PRI_WD_MAX;
      else r = w;
    end
    return r;
  endfunction

  // Reserved bits stay zero because the word starts cleared
  always_comb begin
    word = '0;
    word[DS_WD_MSB:DS_WD_LSB] = legal_width(ds_width, ds_present);
    word[DS_ZERO_LOW_BIT] = ds_zero_low;
    word[DS_PRESENT_BIT] = ds_present;
    word[INT_WD_MSB:INT_WD_LSB] = legal_width(int_width, int_present);
    word[INT_ZERO_LOW_BIT] = int_zero_low;
    word[INT_PRESENT_BIT] = int_present;
  end

endmodule

// file: core/ppi_regs.sv
`timescale 1ns/10ps
module ppi_regs
  import ppi_pkg::*;
#(
  parameter ppi_wd_tab_t DS_WD = DEF_DS_WD,
  parameter ppi_wd_tab_t INT_WD = DEF_INT_WD,
  parameter ppi_bit_tab_t DS_PRESENT = DEF_DS_PRESENT,
  parameter ppi_bit_tab_t INT_PRESENT = DEF_INT_PRESENT,
  parameter ppi_bit_tab_t DS_ZERO_LOW = DEF_DS_ZERO_LOW,
  parameter ppi_bit_tab_t INT_ZERO_LOW = DEF_INT_ZERO_LOW,
  parameter logic INSTANCE_SELECT = DEF_INSTANCE_SELECT,
  parameter logic [15:0] SECURE_PARTITION_LIMIT = DEF_SECURE_PARTITION_LIMIT,
  parameter logic [7:0] SECURE_MONITOR_GROUP_LIMIT = DEF_SECURE_MONITOR_GROUP_LIMIT
)(
  input wire logic clk, // System clock, 50 MHz
  input wire logic rst, // Asynchronous reset, active high
  input wire logic req, // Access request, one cycle
  input wire logic wr, // Access is a write
  input wire logic [1:0] space, // Security space of the access
  input wire logic [ADDR_W-1:0] addr, // Byte offset inside the feature page
  input wire logic [NUM_SPACE-1:0][RIS_W-1:0] ris_sel, // Selected instance per page
  input wire logic secure_map_present, // Secure address map exists
  input wire logic rr_pages_present, // Root and realm pages exist
  output logic ack, // Answer strobe, one cycle
  output logic err, // Access refused, with ack
  output logic [DATA_W-1:0] rdata // Read data, held until next read
);

  // Whole state of the bank: the registered answer
  typedef struct packed {
    logic ack;
    logic err;
    logic [DATA_W-1:0] rdata;
  } ppi_state_t;

  ppi_state_t st_r;
  ppi_state_t st_nxt;

  // One packed feature word per page
  logic [NUM_SPACE-1:0][DATA_W-1:0] pri_word;
  logic [DATA_W-1:0] limits_word;
  ppi_space_t acc_space;

  assign acc_space = ppi_space_t'(space);

  // Each page looks up its own selected instance, so pages never share a copy
  generate
    for (genvar s = 0; s < NUM_SPACE; s++) begin : g_page
      logic [RIS_W-1:0] inst;
      // Without instance selection every page reports instance zero
      assign inst = INSTANCE_SELECT ? ris_sel[s] : '0;
      ppi_pri_word u_word (
        .ds_width(DS_WD[s][inst]),
        .ds_present(DS_PRESENT[s][inst]),
        .ds_zero_low(DS_ZERO_LOW[s][inst]),
        .int_width(INT_WD[s][inst]),
        .int_present(INT_PRESENT[s][inst]),
        .int_zero_low(INT_ZERO_LOW[s][inst]),
        .word(pri_word[s])
      );
    end
  endgenerate

  // Secure limits word; the upper byte is reserved
  always_comb begin
    limits_word = '0;
    limits_word[SMG_MSB:SMG_LSB] = SECURE_MONITOR_GROUP_LIMIT;
    limits_word[SPL_MSB:SPL_LSB] = SECURE_PARTITION_LIMIT;
  end

  // Decode: every request is answered on the next edge, hit or miss
  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = 1'b0;
    st_nxt.err = 1'b0;
    if (req) begin
      st_nxt.ack = 1'b1;
      unique case (addr)
        OFF_PRIORITY_FEATURE: begin
          // Root and realm pages only exist when the system provides them
          if (acc_space == SPACE_ROOT || acc_space == SPACE_REALM) begin
            st_nxt.err = !rr_pages_present;
          end
          if (!st_nxt.err && !wr) begin
            st_nxt.rdata = pri_word[acc_space];
          end
        end
        OFF_SECURE_LIMITS: begin
          // Other pages must not see the secure limits at all
          if (acc_space != SPACE_SECURE || !secure_map_present) begin
            st_nxt.err = 1'b1;
          end else if (!wr) begin
            st_nxt.rdata = limits_word;
          end
        end
        default: begin
          // Unmapped or unaligned offsets are refused and read zero
          st_nxt.err = 1'b1;
          if (!wr) begin
            st_nxt.rdata = '0;
          end
        end
      endcase
      // A write changes nothing and errs only where a read would; read data keeps its last value
      if (wr) begin
        st_nxt.rdata = st_r.rdata;
      end
    end
  end

  // Answer register; reset loads constants only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r.ack <= ACK_RST;
      st_r.err <= ERR_RST;
      st_r.rdata <= RDATA_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from the state register
  assign ack = st_r.ack;
  assign err = st_r.err;
  assign rdata = st_r.rdata;

  // Checks on the answer, all in the clk domain
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Helper: classify the request taken at the current edge
  logic rd_pri_ok;
  logic rd_lim_ok;
  assign rd_pri_ok = req && !wr && addr == OFF_PRIORITY_FEATURE &&
                     (acc_space == SPACE_SECURE || acc_space == SPACE_NONSECURE ||
                      rr_pages_present);
  assign rd_lim_ok = req && !wr && addr == OFF_SECURE_LIMITS &&
                     acc_space == SPACE_SECURE && secure_map_present;

  // Table entries for the page and instance of the current request, read straight
  // from the parameters so the checks do not lean on the packing path
  logic [RIS_W-1:0] chk_inst;
  logic [WD_W-1:0] chk_ds_wd;
  logic [WD_W-1:0] chk_int_wd;
  logic chk_ds_zl;
  logic chk_ds_pr;
  logic chk_int_zl;
  logic chk_int_pr;
  assign chk_inst = INSTANCE_SELECT ? ris_sel[space] : '0;
  assign chk_ds_wd = DS_WD[space][chk_inst];
  assign chk_int_wd = INT_WD[space][chk_inst];
  assign chk_ds_zl = DS_ZERO_LOW[space][chk_inst];
  assign chk_ds_pr = DS_PRESENT[space][chk_inst];
  assign chk_int_zl = INT_ZERO_LOW[space][chk_inst];
  assign chk_int_pr = INT_PRESENT[space][chk_inst];

  // Downstream width stays in range and agrees with presence
  property p_ds_width;
    rd_pri_ok |=> ack && !err && rdata[DS_WD_MSB:DS_WD_LSB] <= PRI_WD_MAX &&
      (rdata[DS_PRESENT_BIT] ? rdata[DS_WD_MSB:DS_WD_LSB] >= PRI_WD_MIN
                             : rdata[DS_WD_MSB:DS_WD_LSB] == '0);
  endproperty
  a_ds_width: assert property (p_ds_width)
    else $error("downstream width out of range");

  // Downstream polarity and presence follow the selected table entry
  property p_ds_bits;
    rd_pri_ok |=> rdata[DS_ZERO_LOW_BIT] == $past(chk_ds_zl) &&
      rdata[DS_PRESENT_BIT] == $past(chk_ds_pr);
  endproperty
  a_ds_bits: assert property (p_ds_bits)
    else $error("downstream polarity or presence wrong");

  // A legal downstream table width is reported exactly for the selected instance
  property p_ds_width_exact;
    rd_pri_ok && chk_ds_pr && chk_ds_wd >= PRI_WD_MIN && chk_ds_wd <= PRI_WD_MAX |=>
      rdata[DS_WD_MSB:DS_WD_LSB] == $past(chk_ds_wd);
  endproperty
  a_ds_width_exact: assert property (p_ds_width_exact)
    else $error("downstream width differs from the selected instance");

  // Internal width stays in range and agrees with presence
  property p_int_width;
    rd_pri_ok |=> rdata[INT_WD_MSB:INT_WD_LSB] <= PRI_WD_MAX &&
      (rdata[INT_PRESENT_BIT] ? rdata[INT_WD_MSB:INT_WD_LSB] >= PRI_WD_MIN
                              : rdata[INT_WD_MSB:INT_WD_LSB] == '0);
  endproperty
  a_int_width: assert property (p_int_width)
    else $error("internal width out of range");

  // Internal polarity and presence follow the selected table entry
  property p_int_bits;
    rd_pri_ok |=> rdata[INT_ZERO_LOW_BIT] == $past(chk_int_zl) &&
      rdata[INT_PRESENT_BIT] == $past(chk_int_pr);
  endproperty
  a_int_bits: assert property (p_int_bits)
    else $error("internal polarity or presence wrong");

  // A legal internal table width is reported exactly for the selected instance
  property p_int_width_exact;
    rd_pri_ok && chk_int_pr && chk_int_wd >= PRI_WD_MIN && chk_int_wd <= PRI_WD_MAX |=>
      rdata[INT_WD_MSB:INT_WD_LSB] == $past(chk_int_wd);
  endproperty
  a_int_width_exact: assert property (p_int_width_exact)
    else $error("internal width differs from the selected instance");

  // Each page returns its own word, reserved bits zero
  property p_page_word;
    rd_pri_ok |=> rdata == $past(pri_word[space]) &&
      rdata[31:26] == '0 && rdata[19:18] == '0 && rdata[15:10] == '0 && rdata[3:2] == '0;
  endproperty
  a_page_word: assert property (p_page_word)
    else $error("priority word mismatch or reserved bit set");

  // Secure limits read back with exact figures
  property p_limits;
    rd_lim_ok |=> ack && !err && rdata[SMG_MSB:SMG_LSB] == SECURE_MONITOR_GROUP_LIMIT &&
      rdata[SPL_MSB:SPL_LSB] == SECURE_PARTITION_LIMIT && rdata[31:24] == '0;
  endproperty
  a_limits: assert property (p_limits)
    else $error("secure limits word wrong");

  // Limits offset from any other page is refused
  property p_limits_other_page;
    req && addr == OFF_SECURE_LIMITS && acc_space != SPACE_SECURE |=> ack && err;
  endproperty
  a_limits_other_page: assert property (p_limits_other_page)
    else $error("secure limits reachable from another page");

  // No secure map means no secure limits word
  property p_no_secure_map;
    req && addr == OFF_SECURE_LIMITS && !secure_map_present |=> ack && err;
  endproperty
  a_no_secure_map: assert property (p_no_secure_map)
    else $error("secure limits reachable without a secure map");

  // Priority word readable from every page while root and realm pages are present
  property p_all_pages;
    req && addr == OFF_PRIORITY_FEATURE && rr_pages_present |=> ack && !err;
  endproperty
  a_all_pages: assert property (p_all_pages)
    else $error("priority word refused on a present page");

  // Root and realm pages are refused when the system lacks them
  property p_rr_absent;
    req && addr == OFF_PRIORITY_FEATURE && !rr_pages_present &&
      (acc_space == SPACE_ROOT || acc_space == SPACE_REALM) |=> ack && err;
  endproperty
  a_rr_absent: assert property (p_rr_absent)
    else $error("priority word answered on an absent page");

  // Unmapped offsets are refused, and a read of one returns zero
  property p_unmapped;
    req && addr != OFF_PRIORITY_FEATURE && addr != OFF_SECURE_LIMITS |=>
      ack && err && ($past(wr) || rdata == '0);
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped offset not refused or read nonzero");

  // Writes are answered and leave the read data untouched
  property p_write_ignored;
    req && wr |=> ack && rdata == $past(rdata);
  endproperty
  a_write_ignored: assert property (p_write_ignored)
    else $error("write changed read data");

  // Exactly one answer per request, none without one
  property p_one_answer;
    (req |=> ack) and (!req |=> !ack && !err);
  endproperty
  a_one_answer: assert property (p_one_answer)
    else $error("answer strobe out of step with request");

  // Main scenarios
  property p_cov_secure_limits;
    rd_lim_ok ##1 ack;
  endproperty
  c_cov_secure_limits: cover property (p_cov_secure_limits);

  property p_cov_realm_read;
    rd_pri_ok && acc_space == SPACE_REALM ##1 ack;
  endproperty
  c_cov_realm_read: cover property (p_cov_realm_read);

  property p_cov_refused;
    req && addr == OFF_SECURE_LIMITS && acc_space == SPACE_NONSECURE ##1 err;
  endproperty
  c_cov_refused: cover property (p_cov_refused);

  property p_cov_write;
    req && wr ##1 ack;
  endproperty
  c_cov_write: cover property (p_cov_write);

endmodule

// file: verif/ppi_regs_tb.sv
`timescale 1ns/10ps
// Self-checking bench: the driver queues notes, the monitor checks each answer
module ppi_regs_tb;
  import ppi_pkg::*;
  // Tables differ per page and instance so a wrong index shows up
  localparam ppi_wd_tab_t TB_DS_WD = {6'h10, 6'h01, 6'h03, 6'h08, 6'h02, 6'h0c, 6'h07, 6'h0f,
    6'h04, 6'h09, 6'h0b, 6'h05, 6'h06, 6'h0a, 6'h0d, 6'h0e};
  localparam ppi_wd_tab_t TB_INT_WD = {6'h01, 6'h10, 6'h0e, 6'h02, 6'h0d, 6'h03, 6'h0c, 6'h04,
    6'h0b, 6'h05, 6'h0a, 6'h06, 6'h09, 6'h07, 6'h08, 6'h0f};
  localparam ppi_bit_tab_t TB_DS_PRESENT = 16'hb7de;
  localparam ppi_bit_tab_t TB_INT_PRESENT = 16'h6dfb;
  localparam ppi_bit_tab_t TB_DS_ZERO_LOW = 16'h5a3c;
  localparam ppi_bit_tab_t TB_INT_ZERO_LOW = 16'hc3a5;
  localparam logic [15:0] TB_SPL = 16'hbe1f;
  localparam logic [7:0] TB_SMG = 8'h9a;
  localparam logic [ADDR_W-1:0] BAD_ADDR [7] = '{12'h000, 12'h004, 12'h00c, 12'h044, 12'h049,
    12'h04c, 12'hffc};
  typedef struct {logic err; logic [DATA_W-1:0] rd; int due;} ppi_note_t;
  logic clk, rst, req, wr, secure_map_present, rr_pages_present, ack, err;
  logic [1:0] space;
  logic [ADDR_W-1:0] addr;
  logic [NUM_SPACE-1:0][RIS_W-1:0] ris_sel;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] last_rd = '0;
  logic [31:0] seed = 32'h000006e6;
  logic [31:0] r;
  int miscompares = 0;
  int checked = 0;
  int cyc = 0;
  ppi_note_t notes[$];
  ppi_note_t mon_n;

  ppi_regs #(.DS_WD(TB_DS_WD), .INT_WD(TB_INT_WD), .DS_PRESENT(TB_DS_PRESENT),
    .INT_PRESENT(TB_INT_PRESENT), .DS_ZERO_LOW(TB_DS_ZERO_LOW), .INT_ZERO_LOW(TB_INT_ZERO_LOW),
    .INSTANCE_SELECT(1'b1), .SECURE_PARTITION_LIMIT(TB_SPL),
    .SECURE_MONITOR_GROUP_LIMIT(TB_SMG)) i_dut (.clk(clk), .rst(rst), .req(req), .wr(wr),
    .space(space), .addr(addr), .ris_sel(ris_sel), .secure_map_present(secure_map_present),
    .rr_pages_present(rr_pages_present), .ack(ack), .err(err), .rdata(rdata));

  // Clock at 50 MHz and a cycle count for latency checks
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Expected feature word; absent fields report width zero
  function automatic logic [31:0] pri_word(int s, int i);
    logic [5:0] dw;
    logic [5:0] iw;
    dw = TB_DS_PRESENT[s][i] ? TB_DS_WD[s][i] : 6'h00;
    iw = TB_INT_PRESENT[s][i] ? TB_INT_WD[s][i] : 6'h00;
    return {6'h00, dw, 2'b00, TB_DS_ZERO_LOW[s][i], TB_DS_PRESENT[s][i], 6'h00, iw, 2'b00,
      TB_INT_ZERO_LOW[s][i], TB_INT_PRESENT[s][i]};
  endfunction

  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic conclude();
    $display("Counts: %0d compared, %0d mismatched", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // One access per call; map level inputs change together with the request
  task automatic access(input logic w, input logic [1:0] sp, input logic [ADDR_W-1:0] a,
      input logic [7:0] rs, input logic sm = 1'b1, input logic rr = 1'b1);
    ppi_note_t n;
    logic pri;
    logic sec;
    @(negedge clk);
    req = 1'b1;
    wr = w;
    space = sp;
    addr = a;
    ris_sel = rs;
    secure_map_present = sm;
    rr_pages_present = rr;
    pri = (a == OFF_PRIORITY_FEATURE) && (sp < 2'd2 || rr);
    sec = (a == OFF_SECURE_LIMITS) && sp == 2'd0 && sm;
    n.err = !(pri || sec);
    if (!w && pri) last_rd = pri_word(sp, ris_sel[sp]);
    else if (!w && sec) last_rd = {8'h00, TB_SMG, TB_SPL};
    else if (!w && a != OFF_PRIORITY_FEATURE && a != OFF_SECURE_LIMITS) last_rd = '0;
    n.rd = last_rd;
    n.due = cyc + 1;
    notes.push_back(n);
  endtask

  task automatic idle(input int k);
    repeat (k) begin
      @(negedge clk);
      req = 1'b0;
    end
  endtask

  // Monitor: each answer takes the oldest note, exactly one cycle after its request
  always @(negedge clk) begin
    if (!rst) begin
      if (ack === 1'b1) begin
        if (notes.size() == 0) chk("spurious ack", 32'h1, 32'h0);
        else begin
          mon_n = notes.pop_front();
          chk("latency", 32'(cyc), 32'(mon_n.due));
          chk("err", {31'h0, err}, {31'h0, mon_n.err});
          chk("rdata", rdata, mon_n.rd);
        end
      end else begin
        chk("err idle", {31'h0, err}, 32'h0);
        if (notes.size() > 0 && notes[0].due <= cyc) begin
          chk("missing ack", 32'h0, 32'h1);
          void'(notes.pop_front());
        end
      end
    end
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    conclude();
  end

  initial begin
    {rst, req, wr, space, addr, ris_sel} = '1;
    {req, wr, space, addr, ris_sel} = '0;
    secure_map_present = 1'b1;
    rr_pages_present = 1'b1;
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    chk("rdata reset", rdata, RDATA_RST);
    // Every page and instance back to back
    for (int s = 0; s < 4; s++)
      for (int i = 0; i < 4; i++) access(1'b0, 2'(s), OFF_PRIORITY_FEATURE, {4{2'(i)}});
    idle(2);
    $display("Test pages done");
    // Limits word from every page, with and without a secure map
    for (int m = 1; m >= 0; m--)
      for (int s = 0; s < 4; s++) access(1'b0, 2'(s), OFF_SECURE_LIMITS, 8'h00, m[0]);
    access(1'b0, 2'd0, OFF_PRIORITY_FEATURE, 8'h03, 1'b0);
    idle(1);
    $display("Test limits done");
    // Writes leave contents alone; then reread
    for (int s = 0; s < 4; s++) begin
      access(1'b1, 2'(s), OFF_PRIORITY_FEATURE, 8'h1b);
      access(1'b1, 2'(s), OFF_SECURE_LIMITS, 8'h1b);
      access(1'b0, 2'(s), OFF_PRIORITY_FEATURE, 8'h1b);
    end
    access(1'b0, 2'd0, OFF_SECURE_LIMITS, 8'h00);
    idle(1);
    $display("Test writes done");
    // Pages without root and realm, then unmapped offsets
    for (int s = 0; s < 4; s++) access(1'b0, 2'(s), OFF_PRIORITY_FEATURE, 8'he4, 1'b1, 1'b0);
    foreach (BAD_ADDR[k]) access(k[0], 2'(k), BAD_ADDR[k], 8'h00);
    idle(1);
    $display("Test refusals done");
    // Random traffic with random gaps
    repeat (300) begin
      r = rnd();
      access(r[4], r[3:2], r[6:5] == 2'd0 ? OFF_SECURE_LIMITS : r[6:5] == 2'd3 ?
        {r[17:8], 2'b00} : OFF_PRIORITY_FEATURE, r[31:24], r[0], r[1]);
      if (r[7]) idle(1);
    end
    idle(2);
    $display("Test random done");
    // Reset in mid-run clears the answer path
    access(1'b0, 2'd1, OFF_PRIORITY_FEATURE, 8'h00);
    @(negedge clk);
    rst = 1'b1;
    req = 1'b0;
    notes.delete();
    last_rd = '0;
    @(negedge clk);
    chk("ack in reset", {31'h0, ack}, 32'h0);
    chk("rdata in reset", rdata, RDATA_RST);
    rst = 1'b0;
    idle(2);
    $display("Test reset done");
    for (int i = 0; i < 10 && notes.size() > 0; i++) idle(1);
    if (notes.size() > 0) miscompares++;
    conclude();
  end
endmodule
